// file: hw/mmu_tlb_pkg.sv
/*
  Shared constants for the translation buffer: register addresses,
  field positions inside the page-entry and control registers,
  buffer geometry. Assumes a 32-bit core data path.
*/
package mmu_tlb_pkg;

  // Buffer geometry
  localparam int NUM_WAYS  = 4;
  localparam int NUM_SETS  = 32;
  localparam int SET_W     = 5;
  localparam int WAY_W     = 2;
  localparam int VPN_W     = 22;
  localparam int SPACE_IDENTIFIER_W    = 8;
  localparam int PPN_W     = 19;
  localparam int PA_W      = 29;

  // Register addresses, as seen by privileged accesses
  localparam logic [31:0] ADDR_TRANSLATION_CONTROL = 32'h0fffffe0;
  localparam logic [31:0] ADDR_PAGE_TABLE_BASE     = 32'h0ffffff8;
  localparam logic [31:0] ADDR_FAULT_VIRT_ADDR     = 32'h0ffffffc;
  localparam logic [31:0] ADDR_PAGE_ENTRY_LOW      = 32'hfffffff4;
  localparam logic [31:0] ADDR_PAGE_ENTRY_HIGH     = 32'hfffffff0;

  // Page-entry-high layout
  localparam int PEH_VPN_LSB  = 10;
  localparam int PEH_VPN_MSB  = 31;
  localparam int PEH_SPACE_IDENTIFIER_LSB = 0;
  localparam int PEH_SPACE_IDENTIFIER_MSB = 7;

  // Page-entry-low layout
  localparam int PEL_PPN_LSB = 10;
  localparam int PEL_PPN_MSB = 28;
  localparam int PEL_V_BIT   = 8;
  localparam int PEL_PR_LSB  = 5;
  localparam int PEL_PR_MSB  = 6;
  localparam int PEL_SZ_BIT  = 4;
  localparam int PEL_C_BIT   = 3;
  localparam int PEL_D_BIT   = 2;
  localparam int PEL_SH_BIT  = 1;

  // Translation control layout
  localparam int TC_AT_BIT  = 0;
  localparam int TC_IX_BIT  = 1;
  localparam int TC_TF_BIT  = 2;
  localparam int TC_RC_LSB  = 4;
  localparam int TC_RC_MSB  = 5;
  localparam int TC_SV_BIT  = 8;

  // Virtual address slices
  localparam int VA_IDX_LSB   = 12;
  localparam int VA_IDX_MSB   = 16;
  localparam int VA_SMALL_LSB = 10;
  localparam int VA_SMALL_MSB = 11;
  localparam int VA_OFF4K_MSB = 11;
  localparam int VA_OFF1K_MSB = 9;

  // Protection codes
  localparam logic [1:0] PR_PRIV_RO = 2'h0;
  localparam logic [1:0] PR_PRIV_RW = 2'h1;
  localparam logic [1:0] PR_ALL_RO  = 2'h2;
  localparam logic [1:0] PR_ALL_RW  = 2'h3;

  localparam logic [WAY_W-1:0] RC_STEP = 2'h1;

endpackage

// file: hw/tlb_way_match.sv
/*
  Tag comparator for one way of the indexed set.
  Purely combinational; the parent registers its result.
*/
`timescale 1ns/1ns
`default_nettype none
module tlb_way_match
  import mmu_tlb_pkg::*;
(
  input  wire logic [VPN_W-1:0]  ent_vpn_i,
  input  wire logic [SPACE_IDENTIFIER_W-1:0] ent_space_identifier_i,
  input  wire logic              ent_valid_i,
  input  wire logic              ent_sz_i,
  input  wire logic              ent_sh_i,
  input  wire logic [VPN_W-1:0]  vpn_i,
  input  wire logic [SPACE_IDENTIFIER_W-1:0] space_identifier_i,
  input  wire logic              single_space_i,
  input  wire logic              priv_i,
  output logic                   hit_o
);

  logic hi_eq;
  logic lo_eq;
  logic space_identifier_eq;

  // Upper page bits always compared; low pair only for small pages
  always_comb
  begin
    hi_eq   = (ent_vpn_i[VPN_W-1:2] == vpn_i[VPN_W-1:2]);
    lo_eq   = ent_sz_i || (ent_vpn_i[1:0] == vpn_i[1:0]);
    space_identifier_eq = ent_sh_i || (single_space_i && priv_i)
              || (ent_space_identifier_i == space_identifier_i);
    hit_o   = ent_valid_i && hi_eq && lo_eq && space_identifier_eq;
  end

endmodule
`default_nettype wire

// file: hw/tlb_access_check.sv
/*
  Permission check for a hit entry: protection field first,
  then the dirty bit. Combinational; parent registers results.
*/
`timescale 1ns/1ns
`default_nettype none
module tlb_access_check
  import mmu_tlb_pkg::*;
(
  input  wire logic [1:0] pr_i,
  input  wire logic       dirty_i,
  input  wire logic       write_i,
  input  wire logic       priv_i,
  output logic            prot_viol_o,
  output logic            init_write_o
);

  logic allowed;

  // Protection decode; violation outranks the dirty check
  always_comb
  begin
    unique case (pr_i)
      PR_PRIV_RO: allowed = priv_i && !write_i;
      PR_PRIV_RW: allowed = priv_i;
      PR_ALL_RO:  allowed = !write_i;
      PR_ALL_RW:  allowed = 1'b1;
    endcase
    prot_viol_o  = !allowed;
    init_write_o = allowed && write_i && !dirty_i;
  end

endmodule
`default_nettype wire

// file: hw/mmu_tlb_lookup_protection.sv
/*
  Translation buffer with lookup, protection check and the five
  translation registers. Assumes the core presents one lookup or
  register access per cycle, synchronous to core_clk_i.
*/
// Functional notes
// - Control registers reachable only in privileged mode
// - Fault loads page-entry-high with upper 22 bits
// - Software writes page/id; load-entry copies them
// - Page-entry-low changes only by software writes
// - Table base is plain software storage
// - Fault address captured and held until next
// - Four ways of 32 entries, common index
// - Index mode clear: page bits 16..12
// - Index mode set: page bits xor identifier
// - Index independent of page size
// - Four ways compared in parallel, valid required
// - Bits 11..10 compared only for small pages
// - Shared entries skip identifier compare
// - Single space plus privileged skips identifier
// - Permitted write to clean page raises initial-write
// - Cacheable bit steers cache, not permission
// - Protection codes gate reads and writes
// - Load-entry writes way chosen by replacement counter
// - Miss updates replacement counter
`timescale 1ns/1ns
`default_nettype none
module mmu_tlb_lookup_protection
  import mmu_tlb_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Register access
  input  wire logic        reg_req_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_priv_i,
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic             reg_ack_o,
  output logic             reg_err_o,
  output logic [31:0]      reg_rdata_o,
  // Entry load and address error
  input  wire logic        load_entry_instruction_i,
  input  wire logic        addr_err_i,
  // Lookup
  input  wire logic        lk_req_i,
  input  wire logic        lk_write_i,
  input  wire logic        lk_priv_i,
  input  wire logic [31:0] lk_vaddr_i,
  output logic             lk_valid_o,
  output logic             lk_hit_o,
  output logic             lk_miss_o,
  output logic             lk_miss_store_o,
  output logic             lk_prot_o,
  output logic             lk_init_write_o,
  output logic             lk_cache_o,
  output logic [31:0]      lk_paddr_o
);

  // Entry storage, flip-flops indexed by way then set; valid bits by set then way
  logic [VPN_W-1:0]  ent_vpn_q   [NUM_WAYS][NUM_SETS];
  logic [VPN_W-1:0]  ent_vpn_d   [NUM_WAYS][NUM_SETS];
  logic [SPACE_IDENTIFIER_W-1:0] ent_space_identifier_q  [NUM_WAYS][NUM_SETS];
  logic [SPACE_IDENTIFIER_W-1:0] ent_space_identifier_d  [NUM_WAYS][NUM_SETS];
  logic [PPN_W-1:0]  ent_ppn_q   [NUM_WAYS][NUM_SETS];
  logic [PPN_W-1:0]  ent_ppn_d   [NUM_WAYS][NUM_SETS];
  logic [6:0]        ent_attr_q  [NUM_WAYS][NUM_SETS];
  logic [6:0]        ent_attr_d  [NUM_WAYS][NUM_SETS];
  logic [NUM_WAYS-1:0] ent_valid_q [NUM_SETS];
  logic [NUM_WAYS-1:0] ent_valid_d [NUM_SETS];

  // Software-visible registers
  logic [31:0]       page_entry_high_q, page_entry_high_d;
  logic [31:0]       page_entry_low_q, page_entry_low_d;
  logic [31:0]       ttb_q, ttb_d;
  logic [31:0]       tea_q, tea_d;
  logic              at_q, at_d;
  logic              ix_q, ix_d;
  logic              sv_q, sv_d;
  logic [WAY_W-1:0]  rc_q, rc_d;

  // Register port outputs
  logic              reg_ack_q, reg_ack_d;
  logic              reg_err_q, reg_err_d;
  logic [31:0]       reg_rdata_q, reg_rdata_d;

  // Lookup outputs
  logic              lk_valid_q, lk_valid_d;
  logic              lk_hit_q, lk_hit_d;
  logic              lk_miss_q, lk_miss_d;
  logic              lk_miss_st_q, lk_miss_st_d;
  logic              lk_prot_q, lk_prot_d;
  logic              lk_initw_q, lk_initw_d;
  logic              lk_cache_q, lk_cache_d;
  logic [31:0]       lk_paddr_q, lk_paddr_d;

  // Lookup datapath
  logic [SPACE_IDENTIFIER_W-1:0] cur_space_identifier;
  logic [VPN_W-1:0]  lk_vpn;
  logic [SET_W-1:0]  lk_set;
  logic [SET_W-1:0]  ld_set;
  logic [NUM_WAYS-1:0] way_hit;
  logic [WAY_W-1:0]  hit_way;
  logic              any_hit;
  logic              translate;
  logic [6:0]        h_attr;
  logic [PPN_W-1:0]  h_ppn;
  logic              prot_viol;
  logic              init_write;
  logic              fault;
  logic              reg_ok;
  logic              flush;

  // Attribute slot positions inside ent_attr
  localparam int AT_SZ = 0;
  localparam int AT_SH = 1;
  localparam int AT_C  = 2;
  localparam int AT_D  = 3;
  localparam int AT_PR = 4;

  // Set index: same bit positions for every page size
  always_comb
  begin
    cur_space_identifier = page_entry_high_q[PEH_SPACE_IDENTIFIER_MSB:PEH_SPACE_IDENTIFIER_LSB];
    lk_vpn   = lk_vaddr_i[PEH_VPN_MSB:PEH_VPN_LSB];
    lk_set   = lk_vaddr_i[VA_IDX_MSB:VA_IDX_LSB];
    ld_set   = page_entry_high_q[VA_IDX_MSB:VA_IDX_LSB];
    if (ix_q)
    begin
      lk_set = lk_set ^ cur_space_identifier[SET_W-1:0];
      ld_set = ld_set ^ cur_space_identifier[SET_W-1:0];
    end
  end

  // One comparator per way, all on the same set
  generate
    for (genvar w = 0; w < NUM_WAYS; w++)
    begin : g_way
      tlb_way_match u_match (
        .ent_vpn_i      (ent_vpn_q[w][lk_set]),
        .ent_space_identifier_i     (ent_space_identifier_q[w][lk_set]),
        .ent_valid_i    (ent_valid_q[lk_set][w]),
        .ent_sz_i       (ent_attr_q[w][lk_set][AT_SZ]),
        .ent_sh_i       (ent_attr_q[w][lk_set][AT_SH]),
        .vpn_i          (lk_vpn),
        .space_identifier_i         (cur_space_identifier),
        .single_space_i (sv_q),
        .priv_i         (lk_priv_i),
        .hit_o          (way_hit[w])
      );
    end
  endgenerate

  // Lowest hitting way wins; multi-hits are software's fault
  always_comb
  begin
    hit_way = '0;
    for (int w = NUM_WAYS - 1; w >= 0; w--)
    begin
      if (way_hit[w])
      begin
        hit_way = WAY_W'(w);
      end
    end
    any_hit = |way_hit;
    h_attr  = ent_attr_q[hit_way][lk_set];
    h_ppn   = ent_ppn_q[hit_way][lk_set];
  end

  tlb_access_check u_check (
    .pr_i         (h_attr[AT_PR+1:AT_PR]),
    .dirty_i      (h_attr[AT_D]),
    .write_i      (lk_write_i),
    .priv_i       (lk_priv_i),
    .prot_viol_o  (prot_viol),
    .init_write_o (init_write)
  );

  // Fixed areas (privileged high half) and a disabled unit skip the buffer
  always_comb
  begin
    translate = at_q && !(lk_priv_i && lk_vaddr_i[31]);
    fault     = lk_req_i && translate && (!any_hit || prot_viol || init_write);
    lk_valid_d   = lk_req_i;
    lk_hit_d     = lk_req_i && translate && any_hit;
    lk_miss_d    = lk_req_i && translate && !any_hit;
    lk_miss_st_d = lk_req_i && translate && !any_hit && lk_write_i;
    lk_prot_d    = lk_req_i && translate && any_hit && prot_viol;
    lk_initw_d   = lk_req_i && translate && any_hit && init_write;
    lk_cache_d   = lk_req_i && translate && any_hit && h_attr[AT_C];
    lk_paddr_d   = {{(32-PA_W){1'b0}}, lk_vaddr_i[PA_W-1:0]};
    if (translate)
    begin
      if (h_attr[AT_SZ])
      begin
        lk_paddr_d = {{(32-PA_W){1'b0}}, h_ppn[PPN_W-1:2], lk_vaddr_i[VA_OFF4K_MSB:0]};
      end
      else
      begin
        lk_paddr_d = {{(32-PA_W){1'b0}}, h_ppn, lk_vaddr_i[VA_OFF1K_MSB:0]};
      end
    end
  end

  // Register decode; user mode is refused outright
  always_comb
  begin
    reg_ok      = reg_req_i && reg_priv_i;
    reg_ack_d   = reg_req_i;
    reg_err_d   = reg_req_i && !reg_priv_i;
    reg_rdata_d = '0;
    flush       = 1'b0;
    page_entry_high_d      = page_entry_high_q;
    page_entry_low_d      = page_entry_low_q;
    ttb_d       = ttb_q;
    tea_d       = tea_q;
    at_d        = at_q;
    ix_d        = ix_q;
    sv_d        = sv_q;
    rc_d        = rc_q;
    if (reg_ok)
    begin
      unique case (reg_addr_i)
        ADDR_PAGE_ENTRY_HIGH:
        begin
          reg_rdata_d = page_entry_high_q;
          if (reg_we_i)
          begin
            page_entry_high_d = reg_wdata_i;
          end
        end
        ADDR_PAGE_ENTRY_LOW:
        begin
          reg_rdata_d = page_entry_low_q;
          if (reg_we_i)
          begin
            page_entry_low_d = reg_wdata_i;
          end
        end
        ADDR_PAGE_TABLE_BASE:
        begin
          reg_rdata_d = ttb_q;
          if (reg_we_i)
          begin
            ttb_d = reg_wdata_i;
          end
        end
        ADDR_FAULT_VIRT_ADDR:
        begin
          reg_rdata_d = tea_q;
          if (reg_we_i)
          begin
            tea_d = reg_wdata_i;
          end
        end
        ADDR_TRANSLATION_CONTROL:
        begin
          reg_rdata_d[TC_AT_BIT]            = at_q;
          reg_rdata_d[TC_IX_BIT]            = ix_q;
          reg_rdata_d[TC_SV_BIT]            = sv_q;
          reg_rdata_d[TC_RC_MSB:TC_RC_LSB]  = rc_q;
          if (reg_we_i)
          begin
            at_d  = reg_wdata_i[TC_AT_BIT];
            ix_d  = reg_wdata_i[TC_IX_BIT];
            sv_d  = reg_wdata_i[TC_SV_BIT];
            rc_d  = reg_wdata_i[TC_RC_MSB:TC_RC_LSB];
            flush = reg_wdata_i[TC_TF_BIT];                      // Flush bit self-clears
          end
        end
        default:
        begin
          reg_err_d = 1'b1;
        end
      endcase
    end
    // Hardware capture after software so a fault in the same cycle wins
    if (fault || addr_err_i)
    begin
      page_entry_high_d[PEH_VPN_MSB:PEH_VPN_LSB] = lk_vaddr_i[PEH_VPN_MSB:PEH_VPN_LSB];
      tea_d = lk_vaddr_i;
    end
    // Besides software writes, replacement counter moves only on a miss
    if (lk_req_i && translate && !any_hit)
    begin
      if (&ent_valid_q[lk_set])
      begin
        rc_d = rc_q + RC_STEP;
      end
      else
      begin
        for (int w = NUM_WAYS - 1; w >= 0; w--)
        begin
          if (!ent_valid_q[lk_set][w])
          begin
            rc_d = WAY_W'(w);
          end
        end
      end
    end
  end

  // Entry updates: flush clears valids, load-entry writes one slot
  always_comb
  begin
    ent_vpn_d   = ent_vpn_q;
    ent_space_identifier_d  = ent_space_identifier_q;
    ent_ppn_d   = ent_ppn_q;
    ent_attr_d  = ent_attr_q;
    ent_valid_d = ent_valid_q;
    if (flush)
    begin
      for (int s = 0; s < NUM_SETS; s++)
      begin
        ent_valid_d[s] = '0;
      end
    end
    if (load_entry_instruction_i)
    begin
      ent_vpn_d[rc_q][ld_set]   = page_entry_high_q[PEH_VPN_MSB:PEH_VPN_LSB];
      ent_space_identifier_d[rc_q][ld_set]  = cur_space_identifier;
      ent_ppn_d[rc_q][ld_set]   = page_entry_low_q[PEL_PPN_MSB:PEL_PPN_LSB];
      ent_attr_d[rc_q][ld_set]  = {1'b0, page_entry_low_q[PEL_PR_MSB:PEL_PR_LSB], page_entry_low_q[PEL_D_BIT],
                                   page_entry_low_q[PEL_C_BIT], page_entry_low_q[PEL_SH_BIT],
                                   page_entry_low_q[PEL_SZ_BIT]};
      ent_valid_d[ld_set][rc_q] = page_entry_low_q[PEL_V_BIT];
    end
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      page_entry_high_q       <= '0;
      page_entry_low_q       <= '0;
      ttb_q        <= '0;
      tea_q        <= '0;
      at_q         <= 1'b0;
      ix_q         <= 1'b0;
      sv_q         <= 1'b0;
      rc_q         <= '0;
      reg_ack_q    <= 1'b0;
      reg_err_q    <= 1'b0;
      reg_rdata_q  <= '0;
      lk_valid_q   <= 1'b0;
      lk_hit_q     <= 1'b0;
      lk_miss_q    <= 1'b0;
      lk_miss_st_q <= 1'b0;
      lk_prot_q    <= 1'b0;
      lk_initw_q   <= 1'b0;
      lk_cache_q   <= 1'b0;
      lk_paddr_q   <= '0;
      for (int s = 0; s < NUM_SETS; s++)
      begin
        ent_valid_q[s] <= '0;
      end
    end
    else if (ce_i)
    begin
      page_entry_high_q       <= page_entry_high_d;
      page_entry_low_q       <= page_entry_low_d;
      ttb_q        <= ttb_d;
      tea_q        <= tea_d;
      at_q         <= at_d;
      ix_q         <= ix_d;
      sv_q         <= sv_d;
      rc_q         <= rc_d;
      reg_ack_q    <= reg_ack_d;
      reg_err_q    <= reg_err_d;
      reg_rdata_q  <= reg_rdata_d;
      lk_valid_q   <= lk_valid_d;
      lk_hit_q     <= lk_hit_d;
      lk_miss_q    <= lk_miss_d;
      lk_miss_st_q <= lk_miss_st_d;
      lk_prot_q    <= lk_prot_d;
      lk_initw_q   <= lk_initw_d;
      lk_cache_q   <= lk_cache_d;
      lk_paddr_q   <= lk_paddr_d;
      ent_valid_q  <= ent_valid_d;
    end
  end

  // Entry contents need no reset; valid bits guard them
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i)
    begin
      ent_vpn_q  <= ent_vpn_d;
      ent_space_identifier_q <= ent_space_identifier_d;
      ent_ppn_q  <= ent_ppn_d;
      ent_attr_q <= ent_attr_d;
    end
  end

  assign reg_ack_o       = reg_ack_q;
  assign reg_err_o       = reg_err_q;
  assign reg_rdata_o     = reg_rdata_q;
  assign lk_valid_o      = lk_valid_q;
  assign lk_hit_o        = lk_hit_q;
  assign lk_miss_o       = lk_miss_q;
  assign lk_miss_store_o = lk_miss_st_q;
  assign lk_prot_o       = lk_prot_q;
  assign lk_init_write_o = lk_initw_q;
  assign lk_cache_o      = lk_cache_q;
  assign lk_paddr_o      = lk_paddr_q;

endmodule
`default_nettype wire

// file: verif/mmu_tlb_checker.sv
/*
  Port-level assertions for the translation buffer top module.
  Assumes it is bound to that module and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module mmu_tlb_checker
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        reg_req_i,
  input  wire logic        reg_priv_i,
  input  wire logic        reg_ack_o,
  input  wire logic        reg_err_o,
  input  wire logic [31:0] reg_rdata_o,
  input  wire logic        lk_req_i,
  input  wire logic        lk_write_i,
  input  wire logic        lk_priv_i,
  input  wire logic [31:0] lk_vaddr_i,
  input  wire logic        lk_valid_o,
  input  wire logic        lk_hit_o,
  input  wire logic        lk_miss_o,
  input  wire logic        lk_miss_store_o,
  input  wire logic        lk_prot_o,
  input  wire logic        lk_init_write_o,
  input  wire logic [31:0] lk_paddr_o
);
  logic [9:0] va_lo;

  // Page offset kept apart so it can be sampled one cycle back
  assign va_lo = lk_vaddr_i[9:0];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // Request acceptance steps
  sequence s_reg_take;
    ce_i && reg_req_i;
  endsequence
  sequence s_lk_take;
    ce_i && lk_req_i;
  endsequence
  sequence s_priv_read;
    s_lk_take ##0 (lk_priv_i && !lk_write_i);
  endsequence

  a_reg_answer: assert property (s_reg_take |=> reg_ack_o)
    else $error("register access not answered");
  a_user_refused: assert property (s_reg_take ##0 !reg_priv_i |=> reg_err_o)
    else $error("user register access not refused");
  a_err_no_data: assert property (reg_ack_o && reg_err_o |-> reg_rdata_o == 32'h0)
    else $error("refused access returned data");
  a_lookup_answer: assert property (s_lk_take |=> lk_valid_o)
    else $error("lookup not answered");
  a_valid_cause: assert property (lk_valid_o && $past(ce_i) |-> $past(lk_req_i))
    else $error("lookup answer without request");
  a_miss_alone: assert property (lk_miss_o |-> !lk_hit_o && !lk_prot_o && !lk_init_write_o)
    else $error("miss flagged with hit or fault");
  a_store_miss: assert property (lk_valid_o && $past(ce_i)
    |-> lk_miss_store_o == (lk_miss_o && $past(lk_write_i)))
    else $error("miss access type wrong");
  a_read_clean: assert property (s_lk_take ##0 !lk_write_i |=> !lk_init_write_o)
    else $error("initial write raised on read");
  a_priv_read: assert property (s_priv_read |=> !lk_prot_o)
    else $error("privileged read refused");
  a_hit_offset: assert property (lk_hit_o && $past(ce_i)
    |-> lk_paddr_o[9:0] == $past(va_lo) && lk_paddr_o[31:29] == 3'h0)
    else $error("hit address offset wrong");
endmodule
`default_nettype wire

// file: verif/core_model.sv
/*
  Behavioural core: issues register accesses, entry loads and lookups
  as one-cycle pulses. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module core_model
(
  input  wire logic        clk_i,
  output logic             ce_o,
  output logic             reg_req_o,
  output logic             reg_we_o,
  output logic             reg_priv_o,
  output logic [31:0]      reg_addr_o,
  output logic [31:0]      reg_wdata_o,
  output logic             load_o,
  output logic             addr_err_o,
  output logic             lk_req_o,
  output logic             lk_write_o,
  output logic             lk_priv_o,
  output logic [31:0]      lk_vaddr_o
);
  // Quiet pins from time zero; the core never stalls the unit
  initial
  begin
    ce_o = 1'b1;
    reg_req_o = 1'b0;
    reg_we_o = 1'b0;
    reg_priv_o = 1'b0;
    reg_addr_o = 32'h0;
    reg_wdata_o = 32'h0;
    load_o = 1'b0;
    addr_err_o = 1'b0;
    lk_req_o = 1'b0;
    lk_write_o = 1'b0;
    lk_priv_o = 1'b0;
    lk_vaddr_o = 32'h0;
  end

  // Stale address and data are inverted so a lingering value shows
  task automatic reg_op(input logic we, input logic pv, input logic [31:0] a,
                        input logic [31:0] d);
    @(posedge clk_i);
    #1;
    reg_req_o = 1'b1;
    reg_we_o = we;
    reg_priv_o = pv;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_req_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic load();
    @(posedge clk_i);
    #1;
    load_o = 1'b1;
    @(posedge clk_i);
    #1;
    load_o = 1'b0;
  endtask

  task automatic lookup(input logic w, input logic pv, input logic [31:0] va);
    @(posedge clk_i);
    #1;
    lk_req_o = 1'b1;
    lk_write_o = w;
    lk_priv_o = pv;
    lk_vaddr_o = va;
    @(posedge clk_i);
    #1;
    lk_req_o = 1'b0;
    lk_vaddr_o = ~va;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
/*
  Self-checking bench for the translation buffer.
  Assumes the core model drives every request input of the unit.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
  end
module tb_top
  import mmu_tlb_pkg::*;
;
  localparam logic [31:0] VA_A  = 32'h0001_2345;
  localparam logic [31:0] PA_A  = 32'h0345_6345;
  localparam logic [31:0] PEL_A = 32'h0345_6100;
  // Row: code[6:5] dirty[4] priv[3] write[2], then fault[1] init-write[0]
  localparam logic [6:0] ROWS [13] = '{7'h18, 7'h1e, 7'h12, 7'h3c, 7'h32, 7'h36, 7'h50,
                                       7'h5e, 7'h56, 7'h74, 7'h65, 7'h68, 7'h0e};
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ce_i, reg_req_i, reg_we_i, reg_priv_i, load_entry_instruction_i;
  logic        addr_err_i, lk_req_i, lk_write_i, lk_priv_i;
  logic [31:0] reg_addr_i, reg_wdata_i, lk_vaddr_i, reg_rdata_o, lk_paddr_o;
  logic        reg_ack_o, reg_err_o, lk_valid_o, lk_hit_o, lk_miss_o;
  logic        lk_miss_store_o, lk_prot_o, lk_init_write_o, lk_cache_o;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;

  mmu_tlb_lookup_protection DUT (.core_clk_i, .reset_i, .ce_i, .reg_req_i, .reg_we_i,
    .reg_priv_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o, .reg_err_o, .reg_rdata_o,
    .load_entry_instruction_i, .addr_err_i, .lk_req_i, .lk_write_i, .lk_priv_i,
    .lk_vaddr_i, .lk_valid_o, .lk_hit_o, .lk_miss_o, .lk_miss_store_o, .lk_prot_o,
    .lk_init_write_o, .lk_cache_o, .lk_paddr_o);

  core_model core (.clk_i(core_clk_i), .ce_o(ce_i), .reg_req_o(reg_req_i),
    .reg_we_o(reg_we_i), .reg_priv_o(reg_priv_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .load_o(load_entry_instruction_i), .addr_err_o(addr_err_i),
    .lk_req_o(lk_req_i), .lk_write_o(lk_write_i), .lk_priv_o(lk_priv_i),
    .lk_vaddr_o(lk_vaddr_i));

  // 125 MHz clock
  always #4 core_clk_i = ~core_clk_i;

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    core.reg_op(1'b1, 1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    core.reg_op(1'b0, 1'b1, a, 32'h0);
    `CHK("register read", e, reg_rdata_o)
  endtask

  // Flags packed as miss, store miss, protection, initial write
  task automatic lk(input logic w, input logic p, input logic [31:0] va, input logic [3:0] e);
    core.lookup(w, p, va);
    `CHK("fault flags", e, {lk_miss_o, lk_miss_store_o, lk_prot_o, lk_init_write_o})
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 160 cycles the run needs
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    logic [6:0] r;
    logic       c;
    repeat (5) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    rd(ADDR_TRANSLATION_CONTROL, 32'h0);
    rd(ADDR_PAGE_TABLE_BASE, 32'h0);
    rd(ADDR_FAULT_VIRT_ADDR, 32'h0);
    done("reset");
    wr(ADDR_PAGE_TABLE_BASE, 32'h5a5a_a5a5);
    rd(ADDR_PAGE_TABLE_BASE, 32'h5a5a_a5a5);
    core.reg_op(1'b1, 1'b0, ADDR_PAGE_TABLE_BASE, 32'hffff_0000);
    `CHK("user refused", 1'b1, reg_err_o)
    core.reg_op(1'b0, 1'b1, 32'h0fff_ffe4, 32'h0);
    `CHK("unmapped refused", 1'b1, reg_err_o)
    rd(ADDR_PAGE_TABLE_BASE, 32'h5a5a_a5a5);
    wr(ADDR_TRANSLATION_CONTROL, 32'h1);
    wr(ADDR_PAGE_ENTRY_HIGH, 32'h0001_2021);
    rd(ADDR_PAGE_ENTRY_HIGH, 32'h0001_2021);
    done("registers");
    // Same slot reloaded per row, so only one way can ever match
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      c = i[0];
      wr(ADDR_PAGE_ENTRY_LOW, PEL_A | (32'(r[6:5]) << 5) | (32'(r[4]) << 2) | (32'(c) << 3));
      core.load();
      lk(r[2], r[3], VA_A, {2'b00, r[1:0]});
      if (r[1:0] == 2'b00)
      begin
        `CHK("hit", 1'b1, lk_hit_o)
        `CHK("cacheable", c, lk_cache_o)
        `CHK("phys addr", PA_A, lk_paddr_o)
      end
    end
    done("protection");
    lk(1'b1, 1'b1, 32'h0003_2456, 4'b1100);
    rd(ADDR_FAULT_VIRT_ADDR, 32'h0003_2456);
    rd(ADDR_PAGE_ENTRY_HIGH, 32'h0003_2421);
    rd(ADDR_PAGE_ENTRY_LOW, PEL_A);
    rd(ADDR_TRANSLATION_CONTROL, 32'h0000_0011);
    lk(1'b0, 1'b1, VA_A, 4'h0);
    rd(ADDR_FAULT_VIRT_ADDR, 32'h0003_2456);
    rd(ADDR_PAGE_TABLE_BASE, 32'h5a5a_a5a5);
    done("miss");
    // Large page lands in the way named by the counter; mapped uncacheable
    wr(ADDR_PAGE_ENTRY_LOW, 32'h0111_0174);
    core.load();
    lk(1'b1, 1'b0, 32'h0003_2c56, 4'h0);
    `CHK("large page addr", 32'h0111_0c56, lk_paddr_o)
    `CHK("uncached", 1'b0, lk_cache_o)
    lk(1'b0, 1'b1, 32'h0001_2c45, 4'b1000);
    rd(ADDR_TRANSLATION_CONTROL, 32'h0000_0021);
    done("page size");
    wr(ADDR_PAGE_ENTRY_HIGH, 32'h0001_2022);
    lk(1'b0, 1'b1, VA_A, 4'b1000);
    wr(ADDR_TRANSLATION_CONTROL, 32'h0000_0101);
    lk(1'b0, 1'b1, VA_A, 4'h0);
    lk(1'b0, 1'b0, VA_A, 4'b1000);
    wr(ADDR_PAGE_ENTRY_LOW, 32'h0345_6166);
    core.load();
    wr(ADDR_PAGE_ENTRY_HIGH, 32'h0001_2033);
    lk(1'b0, 1'b0, VA_A, 4'h0);
    done("identifiers");
    // Mixed index moves this address to another set
    wr(ADDR_TRANSLATION_CONTROL, 32'h0000_0003);
    lk(1'b0, 1'b0, VA_A, 4'b1000);
    core.load();
    lk(1'b0, 1'b0, VA_A, 4'h0);
    wr(ADDR_TRANSLATION_CONTROL, 32'h0000_0007);
    rd(ADDR_TRANSLATION_CONTROL, 32'h0000_0003);
    lk(1'b0, 1'b0, VA_A, 4'b1000);
    done("index");
    print_verdict();
  end
endmodule

bind mmu_tlb_lookup_protection mmu_tlb_checker chk (.core_clk_i, .reset_i, .ce_i,
  .reg_req_i, .reg_priv_i, .reg_ack_o, .reg_err_o, .reg_rdata_o, .lk_req_i, .lk_write_i,
  .lk_priv_i, .lk_vaddr_i, .lk_valid_o, .lk_hit_o, .lk_miss_o, .lk_miss_store_o,
  .lk_prot_o, .lk_init_write_o, .lk_paddr_o);
`default_nettype wire
